// file: subtract_w_pkg.sv
package subtract_w_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int DATA_W      = 8;
    localparam int ADDR_W      = 8;
    localparam int BANK_W      = 4;
    localparam int FULL_ADDR_W = 12;

    // ------------------------------------------------------------
    // Addressing constants
    // ------------------------------------------------------------
    localparam logic [7:0]  INDEXED_LIMIT    = 8'h5F;
    localparam logic [7:0]  ACCESS_SPLIT     = 8'h60;
    localparam logic [3:0]  ACCESS_LOW_BANK  = 4'h0;
    localparam logic [3:0]  ACCESS_HIGH_BANK = 4'hF;
    localparam logic [3:0]  NIBBLE_MSB       = 4'h8;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0]  ACC_RESET   = 8'h00;
    localparam logic [11:0] ADDR_RESET  = 12'h000;

    // ------------------------------------------------------------
    // Operation kinds
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        OP_IDLE    = 3'b001,
        OP_FILE    = 3'b010,
        OP_LITERAL = 3'b100
    } op_kind_type;

endpackage : subtract_w_pkg

// file: subtract_core.sv
`timescale 1ns/1ps
`default_nettype none

// Combinational 8-bit subtract with flags
module subtract_core
    import subtract_w_pkg::*;
(
    input  wire logic [7:0] minuend_in,
    input  wire logic [7:0] subtrahend_in,
    output logic      [7:0] diff_out,
    output logic            carry_out,
    output logic            digit_carry_out,
    output logic            overflow_out,
    output logic            negative_out,
    output logic            zero_out
);

    logic [8:0] full_sum;
    logic [4:0] low_sum;

    // Two's complement: a + ~b + 1
    always_comb
    begin
        full_sum        = {1'b0, minuend_in} + {1'b0, ~subtrahend_in} + 9'h001;
        low_sum         = {1'b0, minuend_in[3:0]} + {1'b0, ~subtrahend_in[3:0]} + 5'h01;
        diff_out        = full_sum[7:0];
        carry_out       = full_sum[8];
        digit_carry_out = low_sum[4];
        overflow_out    = (minuend_in[7] != subtrahend_in[7]) && (full_sum[7] != minuend_in[7]);
        negative_out    = full_sum[7];
        zero_out        = (full_sum[7:0] == 8'h00);
    end

endmodule // subtract_core

`default_nettype wire

// file: subtract_w_datapath.sv
`timescale 1ns/1ps
`default_nettype none

// Contract
// - File form writes file register minus working register to the chosen destination.
// - Subtraction is 8-bit two's complement so negative results wrap.
// - Destination bit zero writes the working register and leaves the file register.
// - Destination bit one writes the result back to the addressed file register.
// - Access bit zero resolves the operand inside the access bank.
// - Access bit one uses the bank select register to pick the register bank.
// - Access bit zero with extended set and address up to 5Fh uses indexed literal offset.
module subtract_w_datapath
    import subtract_w_pkg::*;
(
    input  wire logic        clk_sys_in,
    input  wire logic        sys_rst_in,
    input  wire logic        exec_file_in,
    input  wire logic        exec_literal_in,
    input  wire logic [7:0]  operand_addr_in,
    input  wire logic [7:0]  literal_in,
    input  wire logic        dest_sel_in,
    input  wire logic        access_sel_in,
    input  wire logic        ext_set_en_in,
    input  wire logic [3:0]  bank_select_reg_in,
    input  wire logic [11:0] index_base_in,
    input  wire logic [7:0]  file_data_in,
    output logic      [11:0] file_addr_out,
    output logic             file_indexed_out,
    output logic      [7:0]  file_wdata_out,
    output logic             file_we_out,
    output logic      [7:0]  acc_out,
    output logic             carry_flag_out,
    output logic             digit_carry_flag_out,
    output logic             overflow_flag_out,
    output logic             negative_flag_out,
    output logic             zero_flag_out,
    output logic             done_out
);

    // ------------------------------------------------------------
    // Address resolution
    // ------------------------------------------------------------
    logic [11:0] addr_next;
    logic        indexed_next;

    always_comb
    begin
        addr_next    = ADDR_RESET;
        indexed_next = 1'b0;
        if (!access_sel_in && ext_set_en_in && operand_addr_in <= INDEXED_LIMIT)
        begin
            addr_next    = index_base_in + {4'h0, operand_addr_in};
            indexed_next = 1'b1;
        end
        else if (!access_sel_in)
        begin
            if (operand_addr_in < ACCESS_SPLIT)
                addr_next = {ACCESS_LOW_BANK, operand_addr_in};
            else
                addr_next = {ACCESS_HIGH_BANK, operand_addr_in};
        end
        else
        begin
            addr_next = {bank_select_reg_in, operand_addr_in};
        end
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (sys_rst_in)
        begin
            file_addr_out    <= ADDR_RESET;
            file_indexed_out <= 1'b0;
        end
        else
        begin
            file_addr_out    <= addr_next;
            file_indexed_out <= indexed_next;
        end
    end

    // ------------------------------------------------------------
    // Arithmetic
    // ------------------------------------------------------------
    op_kind_type op_kind;
    logic [7:0]  minuend;
    logic [7:0]  diff;
    logic        c_next;
    logic        digit_carry_next;
    logic        overflow_next;
    logic        n_next;
    logic        z_next;

    always_comb
    begin
        if (exec_file_in)
            op_kind = OP_FILE;
        else if (exec_literal_in)
            op_kind = OP_LITERAL;
        else
            op_kind = OP_IDLE;
    end

    always_comb
    begin
        case (op_kind)
            OP_FILE:    minuend = file_data_in;
            OP_LITERAL: minuend = literal_in;
            default:    minuend = file_data_in;
        endcase
    end

    subtract_core u_core (
        .minuend_in      (minuend),
        .subtrahend_in   (acc_out),
        .diff_out        (diff),
        .carry_out       (c_next),
        .digit_carry_out (digit_carry_next),
        .overflow_out    (overflow_next),
        .negative_out    (n_next),
        .zero_out        (z_next)
    );

    // ------------------------------------------------------------
    // Destination write
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_in)
    begin
        if (sys_rst_in)
            acc_out <= ACC_RESET;
        else if ((op_kind == OP_FILE && !dest_sel_in) || op_kind == OP_LITERAL)
            acc_out <= diff;
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (sys_rst_in)
        begin
            file_we_out    <= 1'b0;
            file_wdata_out <= ACC_RESET;
        end
        else
        begin
            file_we_out    <= (op_kind == OP_FILE) && dest_sel_in;
            file_wdata_out <= diff;
        end
    end

    // ------------------------------------------------------------
    // Status flags
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_in)
    begin
        if (sys_rst_in)
        begin
            carry_flag_out       <= 1'b0;
            digit_carry_flag_out <= 1'b0;
            overflow_flag_out    <= 1'b0;
            negative_flag_out    <= 1'b0;
            zero_flag_out        <= 1'b0;
            done_out             <= 1'b0;
        end
        else
        begin
            done_out <= (op_kind != OP_IDLE);
            if (op_kind != OP_IDLE)
            begin
                carry_flag_out       <= c_next;
                digit_carry_flag_out <= digit_carry_next;
                overflow_flag_out    <= overflow_next;
                negative_flag_out    <= n_next;
                zero_flag_out        <= z_next;
            end
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    property p_file_result;
        @(posedge clk_sys_in) disable iff (sys_rst_in)
        (exec_file_in && dest_sel_in) |=> file_we_out
            && (file_wdata_out == 8'($past(file_data_in) - $past(acc_out)));
    endproperty
    a_file_result: assert property (p_file_result) else $error("file result wrong");

    property p_wrap;
        @(posedge clk_sys_in) disable iff (sys_rst_in)
        (exec_literal_in && !exec_file_in && literal_in < acc_out)
            |=> negative_flag_out == acc_out[7] && !carry_flag_out;
    endproperty
    a_wrap: assert property (p_wrap) else $error("borrow not wrapped");

    property p_dest_w;
        @(posedge clk_sys_in) disable iff (sys_rst_in)
        (exec_file_in && !dest_sel_in) |=> !file_we_out
            && acc_out == 8'($past(file_data_in) - $past(acc_out));
    endproperty
    a_dest_w: assert property (p_dest_w) else $error("dest W wrong");

    property p_dest_f;
        @(posedge clk_sys_in) disable iff (sys_rst_in)
        (exec_file_in && dest_sel_in) |=> file_we_out && $stable(acc_out);
    endproperty
    a_dest_f: assert property (p_dest_f) else $error("dest f wrong");

    property p_access;
        @(posedge clk_sys_in) disable iff (sys_rst_in)
        (!access_sel_in && !ext_set_en_in) |=> !file_indexed_out
            && file_addr_out[7:0] == $past(operand_addr_in)
            && file_addr_out[11:8] == (($past(operand_addr_in) < ACCESS_SPLIT)
                ? ACCESS_LOW_BANK : ACCESS_HIGH_BANK);
    endproperty
    a_access: assert property (p_access) else $error("access bank wrong");

    property p_bank;
        @(posedge clk_sys_in) disable iff (sys_rst_in)
        access_sel_in |=> file_addr_out == {$past(bank_select_reg_in), $past(operand_addr_in)};
    endproperty
    a_bank: assert property (p_bank) else $error("bank select wrong");

    property p_indexed;
        @(posedge clk_sys_in) disable iff (sys_rst_in)
        (!access_sel_in && ext_set_en_in && operand_addr_in <= INDEXED_LIMIT) |=> file_indexed_out;
    endproperty
    a_indexed: assert property (p_indexed) else $error("indexed mode missed");

    property p_flags;
        @(posedge clk_sys_in) disable iff (sys_rst_in)
        (exec_file_in && !dest_sel_in) |=> zero_flag_out == (acc_out == 8'h00)
            && negative_flag_out == acc_out[7];
    endproperty
    a_flags: assert property (p_flags) else $error("flags wrong");

    c_file_f:  cover property (@(posedge clk_sys_in) exec_file_in && dest_sel_in);
    c_literal: cover property (@(posedge clk_sys_in) exec_literal_in && !exec_file_in);
    c_indexed: cover property (@(posedge clk_sys_in) file_indexed_out);
    c_zero:    cover property (@(posedge clk_sys_in) done_out && zero_flag_out);

endmodule // subtract_w_datapath

`default_nettype wire

// file: tb.sv
`timescale 1ns/1ps
`default_nettype none

module tb
    import subtract_w_pkg::*;
;

    typedef struct packed {
        logic [7:0]  acc;
        logic [7:0]  wdata;
        logic        we;
        logic [4:0]  flags;
        logic        file_op;
        logic [11:0] addr;
        logic        idx;
    } note_type;

    logic        clk_sys_in      = 1'b0;
    logic        sys_rst_in      = 1'b1;
    logic        exec_file_in    = 1'b0;
    logic        exec_literal_in = 1'b0;
    logic [7:0]  operand_addr_in = 8'h00;
    logic [7:0]  literal_in      = 8'h00;
    logic        dest_sel_in     = 1'b0;
    logic        access_sel_in   = 1'b0;
    logic        ext_set_en_in   = 1'b0;
    logic [3:0]  bank_sel_in     = 4'h0;
    logic [11:0] index_base_in   = 12'h000;
    logic [7:0]  file_data_in    = 8'h00;
    logic [11:0] file_addr_out;
    logic        file_indexed_out;
    logic [7:0]  file_wdata_out;
    logic        file_we_out;
    logic [7:0]  acc_out;
    logic        carry_flag_out;
    logic        digit_carry_flag_out;
    logic        overflow_flag_out;
    logic        negative_flag_out;
    logic        zero_flag_out;
    logic        done_out;
    note_type    note_q[$];
    note_type    got;
    logic [7:0]  w_model;
    logic [31:0] r1;
    logic [31:0] r2;
    int          error_cnt   = 0;
    int          check_count = 0;
    integer      seed        = 32'hBD1530A8;

    always #5 clk_sys_in = ~clk_sys_in;

    subtract_w_datapath u_dut (
        .clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .exec_file_in(exec_file_in),
        .exec_literal_in(exec_literal_in), .operand_addr_in(operand_addr_in),
        .literal_in(literal_in), .dest_sel_in(dest_sel_in), .access_sel_in(access_sel_in),
        .ext_set_en_in(ext_set_en_in), .bank_select_reg_in(bank_sel_in),
        .index_base_in(index_base_in), .file_data_in(file_data_in),
        .file_addr_out(file_addr_out), .file_indexed_out(file_indexed_out),
        .file_wdata_out(file_wdata_out), .file_we_out(file_we_out), .acc_out(acc_out),
        .carry_flag_out(carry_flag_out), .digit_carry_flag_out(digit_carry_flag_out),
        .overflow_flag_out(overflow_flag_out), .negative_flag_out(negative_flag_out),
        .zero_flag_out(zero_flag_out), .done_out(done_out)
    );

    // ----------------
    // Checking
    // ----------------
    task automatic check(input logic ok, input string msg);
        check_count++;
        if (ok !== 1'b1)
        begin
            error_cnt++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask

    task automatic stop_test;
        if (error_cnt == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    always @(negedge clk_sys_in)
    begin
        if (done_out === 1'b1)
        begin
            check(note_q.size() > 0, "unexpected done");
            if (note_q.size() > 0)
            begin
                got = note_q.pop_front();
                check(acc_out === got.acc, "acc");
                check({negative_flag_out, overflow_flag_out, carry_flag_out,
                       digit_carry_flag_out, zero_flag_out} === got.flags, "flags");
                check(file_we_out === got.we, "write enable");
                if (got.we) check(file_wdata_out === got.wdata, "write data");
                if (got.file_op) check(file_addr_out === got.addr, "address");
                if (got.file_op) check(file_indexed_out === got.idx, "indexed");
            end
        end
        else if (file_we_out !== 1'b0 && !sys_rst_in)
            check(1'b0, "stray write");
    end

    // ----------------
    // Stimulus
    // ----------------
    task automatic issue(input logic fe, input logic le, input logic [7:0] f,
                         input logic [7:0] k, input logic d, input logic a, input logic x,
                         input logic [3:0] bk, input logic [11:0] base, input logic [7:0] fd);
        note_type   n;
        logic [7:0] op_a;
        logic [7:0] res;
        @(posedge clk_sys_in);
        exec_file_in    <= fe;
        exec_literal_in <= le;
        operand_addr_in <= f;
        literal_in      <= k;
        dest_sel_in     <= d;
        access_sel_in   <= a;
        ext_set_en_in   <= x;
        bank_sel_in     <= bk;
        index_base_in   <= base;
        file_data_in    <= fd;
        op_a = fe ? fd : k;
        res = op_a - w_model;
        n.acc = (fe && d) ? w_model : res;
        n.wdata = res;
        n.we = fe & d;
        n.flags = {res[7], (op_a[7] != w_model[7]) && (res[7] != op_a[7]),
                   op_a >= w_model, op_a[3:0] >= w_model[3:0], res == 8'h00};
        n.file_op = fe;
        n.idx = !a && x && f <= INDEXED_LIMIT;
        n.addr = a ? {bk, f} : n.idx ? base + {4'h0, f} :
                 {(f < ACCESS_SPLIT) ? ACCESS_LOW_BANK : ACCESS_HIGH_BANK, f};
        if (fe || le)
        begin
            w_model = n.acc;
            note_q.push_back(n);
        end
    endtask

    task automatic drain;
        issue(0, 0, 8'h00, 8'h00, 0, 0, 0, 4'h0, 12'h000, 8'h00);
        repeat (3) @(posedge clk_sys_in);
        check(note_q.size() == 0, "missing done");
    endtask

    task automatic rand_ops(input int cnt);
        for (int i = 0; i < cnt; i++)
        begin
            r1 = $random(seed);
            r2 = $random(seed);
            issue(r1[0], r1[1], r1[16:9], r1[24:17], r1[2], r1[3], r1[4], r1[8:5],
                  r2[11:0], r2[19:12]);
        end
    endtask

    initial
    begin
        w_model = ACC_RESET;
        repeat (2) @(posedge clk_sys_in);
        sys_rst_in <= 1'b0;
        issue(0, 1, 8'h10, 8'h02, 0, 0, 0, 4'h0, 12'h000, 8'h00);
        issue(1, 0, 8'h10, 8'h00, 1, 0, 0, 4'h0, 12'h000, 8'h03);
        issue(1, 0, 8'h10, 8'h00, 0, 0, 0, 4'h0, 12'h000, 8'h02);
        issue(0, 1, 8'h10, 8'h02, 0, 0, 0, 4'h0, 12'h000, 8'h00);
        issue(1, 0, 8'h10, 8'h00, 1, 0, 0, 4'h0, 12'h000, 8'h01);
        issue(0, 1, 8'h10, 8'h03, 0, 0, 0, 4'h0, 12'h000, 8'h00);
        issue(0, 1, 8'h10, 8'h02, 0, 0, 0, 4'h0, 12'h000, 8'h00);
        // Addresses 5Eh to 65h around the indexed limit and access split
        for (int i = 0; i < 16; i++)
            issue(1, i[0], 8'h5E + i[3:1], 8'h00, i[1], i[3] & i[2], ~i[2], 4'hA,
                  12'hFF0, 8'h80);
        drain();
        rand_ops(400);
        drain();
        @(posedge clk_sys_in);
        sys_rst_in <= 1'b1;
        repeat (2) @(posedge clk_sys_in);
        sys_rst_in <= 1'b0;
        w_model = ACC_RESET;
        @(negedge clk_sys_in);
        check(acc_out === ACC_RESET, "reset acc");
        rand_ops(200);
        drain();
        stop_test();
    end

    initial
    begin
        #100000;
        error_cnt++;
        stop_test();
    end

endmodule // tb

`default_nettype wire
